// [src/fsp_pkg.sv]
// Constants for the fast call and return privilege unit.
// Assumes a 64-bit core with 48-bit virtual addresses.
package fsp_pkg;

  // Configuration register fields
  localparam int RET_SEL_HI  = 63;
  localparam int RET_SEL_LO  = 48;
  localparam int CALL_SEL_HI = 47;
  localparam int CALL_SEL_LO = 32;
  localparam int EIP_HI      = 31;
  localparam int EIP_LO      = 0;

  // Selector offsets added to the configured base selector field
  localparam logic [15:0] SEL_STEP_SS   = 16'h0008;
  localparam logic [15:0] SEL_STEP_CS64 = 16'h0010;

  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_USER   = 2'h3;

  // Implemented virtual address width for the canonical check
  localparam int VA_BITS = 48;

  localparam logic [63:0] REG_RESET = 64'h0;

  // Model-register write target select
  typedef enum logic [2:0] {
    FSP_REG_CFG    = 3'h0,
    FSP_REG_LONG   = 3'h1,
    FSP_REG_COMPAT = 3'h2,
    FSP_REG_MASK   = 3'h3,
    FSP_REG_OTHER  = 3'h4
  } fsp_reg_t;

  // Instruction classes decoded upstream
  typedef enum logic [4:0] {
    FSP_OP_NONE          = 5'h00,
    FSP_OP_FAST_CALL     = 5'h01,
    FSP_OP_FAST_RETURN   = 5'h02,
    FSP_OP_MODEL_WRITE   = 5'h03,
    FSP_OP_SET_GLOBAL    = 5'h04,
    FSP_OP_BASE_SWAP     = 5'h05,
    FSP_OP_LEGACY_RETURN = 5'h06,
    FSP_OP_GUEST_LOAD    = 5'h07,
    FSP_OP_GUEST_SAVE    = 5'h08,
    FSP_OP_GUEST_RUN     = 5'h09,
    FSP_OP_HYPER_CALL    = 5'h0a,
    FSP_OP_CACHE_WBINV   = 5'h0b,
    FSP_OP_SET_INT_FLAG  = 5'h0c,
    FSP_OP_STORE_MSW     = 5'h0d,
    FSP_OP_STORE_TASK    = 5'h0e,
    FSP_OP_LEGACY_CALL   = 5'h0f,
    FSP_OP_UNDEF         = 5'h10,
    FSP_OP_SEG_RD_VERIFY = 5'h11,
    FSP_OP_SEG_WR_VERIFY = 5'h12,
    FSP_OP_FS_BASE_WRITE = 5'h13,
    FSP_OP_GS_BASE_WRITE = 5'h14
  } fsp_op_t;

endpackage

// [src/fsp_unit.sv]
// Fast call/return privilege unit: holds the four call registers,
// checks instruction privilege and produces the segment/flag updates.
// Assumes the decoder presents one instruction per cycle with a valid
// strobe and that the core applies the results when done_o pulses.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - 32-bit return: code selector equals return field
// - 64-bit return: code selector is field plus 16
// - Return stack selector is field plus 8
// - Call: code from call field, stack plus 8
// - Legacy call target from low 32 bits
// - 64-bit caller uses long target register
// - Compatibility caller uses compat target register
// - Non-canonical target write raises protection fault
// - Call clears flags where mask bit set
// - Flag mask applies only in long mode
// - Fixed selector values, no descriptor checks
// - Fast call sets privilege level 0
// - Fast return sets privilege level 3
// - Target selector privilege never checked
// - Listed system instructions need privilege 0
// - OS setting governs interrupt-flag instruction privilege
// - Listed instructions allowed at any level
module fsp_unit
  import fsp_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        op_valid_i,
  input  wire fsp_op_t     op_i,
  input  wire logic [1:0]  cur_priv_i,
  input  wire logic        long_mode_i,
  input  wire logic        code_64_i,
  input  wire logic        ret_to_64_i,
  input  wire logic        int_flag_user_ok_i,
  input  wire fsp_reg_t    wr_reg_i,
  input  wire logic [63:0] wr_data_i,
  input  wire logic [63:0] flags_i,
  output logic             done_o,
  output logic             gp_fault_o,
  output logic             seg_load_o,
  output logic [15:0]      code_sel_o,
  output logic [15:0]      stack_sel_o,
  output logic [1:0]       new_priv_o,
  output logic [63:0]      target_ip_o,
  output logic [63:0]      flags_o,
  output logic [63:0]      cfg_o,
  output logic [63:0]      long_tgt_o,
  output logic [63:0]      compat_tgt_o,
  output logic [63:0]      mask_o
);

  logic [63:0] call_selector_target_config_q;
  logic [63:0] long_call_target_pointer_q;
  logic [63:0] compat_call_target_pointer_q;
  logic [63:0] call_flag_clear_mask_q;
  logic [15:0] ret_sel;
  logic [15:0] call_sel;
  logic        kernel_only;
  logic        priv_ok;
  logic        canon_ok;
  logic        tgt_write;
  logic        accept;

  assign ret_sel  = call_selector_target_config_q[RET_SEL_HI:RET_SEL_LO];
  assign call_sel = call_selector_target_config_q[CALL_SEL_HI:CALL_SEL_LO];

  always_comb begin
    unique case (op_i)
      FSP_OP_SET_GLOBAL, FSP_OP_BASE_SWAP, FSP_OP_LEGACY_RETURN,
      FSP_OP_FAST_RETURN, FSP_OP_GUEST_LOAD, FSP_OP_GUEST_SAVE,
      FSP_OP_GUEST_RUN, FSP_OP_HYPER_CALL, FSP_OP_CACHE_WBINV,
      FSP_OP_MODEL_WRITE: kernel_only = 1'b1;
      default:            kernel_only = 1'b0;
    endcase
  end

  always_comb begin
    if (op_i == FSP_OP_SET_INT_FLAG) begin
      priv_ok = (cur_priv_i == PRIV_KERNEL) || int_flag_user_ok_i;
    end else if (kernel_only) begin
      priv_ok = (cur_priv_i == PRIV_KERNEL);
    end else begin
      priv_ok = 1'b1;
    end
  end

  // canonical check: bits above the VA width copy its top bit
  assign canon_ok = (wr_data_i[63:VA_BITS-1] == {(65-VA_BITS){1'b0}}) ||
                    (wr_data_i[63:VA_BITS-1] == {(65-VA_BITS){1'b1}});
  assign tgt_write = (wr_reg_i == FSP_REG_LONG) ||
                     (wr_reg_i == FSP_REG_COMPAT);
  assign accept = op_valid_i && priv_ok &&
                  !((op_i == FSP_OP_MODEL_WRITE) && tgt_write && !canon_ok);

  // Register writes; a faulting write leaves the target untouched
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      call_selector_target_config_q <= REG_RESET;
      long_call_target_pointer_q    <= REG_RESET;
      compat_call_target_pointer_q  <= REG_RESET;
      call_flag_clear_mask_q        <= REG_RESET;
    end else if (accept && op_i == FSP_OP_MODEL_WRITE) begin
      unique case (wr_reg_i)
        FSP_REG_CFG:    call_selector_target_config_q <= wr_data_i;
        FSP_REG_LONG:   long_call_target_pointer_q    <= wr_data_i;
        FSP_REG_COMPAT: compat_call_target_pointer_q  <= wr_data_i;
        FSP_REG_MASK:   call_flag_clear_mask_q        <= wr_data_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o     <= 1'b0;
      gp_fault_o <= 1'b0;
    end else begin
      done_o     <= accept;
      gp_fault_o <= op_valid_i && !accept;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_load_o  <= 1'b0;
      code_sel_o  <= 16'h0000;
      stack_sel_o <= 16'h0000;
      new_priv_o  <= PRIV_KERNEL;
      target_ip_o <= 64'h0;
      flags_o     <= 64'h0;
    end else begin
      seg_load_o <= 1'b0;
      if (accept && op_i == FSP_OP_FAST_CALL) begin
        seg_load_o  <= 1'b1;
        code_sel_o  <= call_sel;
        stack_sel_o <= call_sel + SEL_STEP_SS;
        new_priv_o  <= PRIV_KERNEL;
        if (long_mode_i && code_64_i) begin
          target_ip_o <= long_call_target_pointer_q;
        end else if (long_mode_i) begin
          target_ip_o <= compat_call_target_pointer_q;
        end else begin
          target_ip_o <= {32'h0, call_selector_target_config_q[EIP_HI:EIP_LO]};
        end
        flags_o <= long_mode_i ? (flags_i & ~call_flag_clear_mask_q) : flags_i;
      end else if (accept && op_i == FSP_OP_FAST_RETURN) begin
        seg_load_o  <= 1'b1;
        code_sel_o  <= ret_to_64_i ? ret_sel + SEL_STEP_CS64 : ret_sel;
        stack_sel_o <= ret_sel + SEL_STEP_SS;
        new_priv_o  <= PRIV_USER;
        flags_o     <= flags_i;
      end
    end
  end

  assign cfg_o        = call_selector_target_config_q;
  assign long_tgt_o   = long_call_target_pointer_q;
  assign compat_tgt_o = compat_call_target_pointer_q;
  assign mask_o       = call_flag_clear_mask_q;

endmodule

`default_nettype wire

// [sim/fsp_unit_chk.sv]
// Port checker for the fast call unit.
// Assumes every answer comes one cycle after its request.
`timescale 1ns/10ps
`default_nettype none
module fsp_unit_chk
  import fsp_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        op_valid_i,
  input wire fsp_op_t     op_i,
  input wire logic [1:0]  cur_priv_i,
  input wire logic        long_mode_i,
  input wire logic        code_64_i,
  input wire logic        ret_to_64_i,
  input wire logic [63:0] flags_i,
  input wire logic        done_o,
  input wire logic        gp_fault_o,
  input wire logic [15:0] code_sel_o,
  input wire logic [15:0] stack_sel_o,
  input wire logic [1:0]  new_priv_o,
  input wire logic [63:0] target_ip_o,
  input wire logic [63:0] flags_o,
  input wire logic [63:0] cfg_o,
  input wire logic [63:0] long_tgt_o,
  input wire logic [63:0] mask_o
);
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic call_w, ret_w, lim_w;
  assign call_w = op_valid_i && op_i == FSP_OP_FAST_CALL;
  assign ret_w = op_valid_i && op_i == FSP_OP_FAST_RETURN && cur_priv_i == 2'h0;
  assign lim_w = op_i inside {FSP_OP_MODEL_WRITE, FSP_OP_SET_GLOBAL,
    FSP_OP_BASE_SWAP, FSP_OP_LEGACY_RETURN, FSP_OP_FAST_RETURN,
    FSP_OP_GUEST_LOAD, FSP_OP_GUEST_SAVE, FSP_OP_GUEST_RUN,
    FSP_OP_HYPER_CALL, FSP_OP_CACHE_WBINV};
  property p_call;
    call_w |=> done_o && code_sel_o == $past(cfg_o[47:32]) && new_priv_o == 2'h0
      && stack_sel_o == $past(cfg_o[47:32]) + 16'h0008;
  endproperty
  a_call: assert property (p_call) else $error("call selectors");
  property p_ret32;
    ret_w && !ret_to_64_i |=> code_sel_o == $past(cfg_o[63:48])
      && stack_sel_o == $past(cfg_o[63:48]) + 16'h0008 && new_priv_o == 2'h3;
  endproperty
  a_ret32: assert property (p_ret32) else $error("ret32 sel");
  property p_ret64;
    ret_w && ret_to_64_i |=> code_sel_o == $past(cfg_o[63:48]) + 16'h0010;
  endproperty
  a_ret64: assert property (p_ret64) else $error("ret64 sel");
  property p_mask;
    call_w && long_mode_i |=> flags_o == ($past(flags_i) & ~$past(mask_o));
  endproperty
  a_mask: assert property (p_mask) else $error("flag mask");
  property p_legacy;
    call_w && !long_mode_i |=> flags_o == $past(flags_i)
      && target_ip_o == {32'h0, $past(cfg_o[31:0])};
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy call");
  property p_ip64;
    call_w && long_mode_i && code_64_i |=> target_ip_o == $past(long_tgt_o);
  endproperty
  a_ip64: assert property (p_ip64) else $error("long target");
  property p_priv;
    op_valid_i && lim_w && cur_priv_i != 2'h0 |=> gp_fault_o && !done_o;
  endproperty
  a_priv: assert property (p_priv) else $error("no fault");
  property p_idle;
    !op_valid_i |=> !done_o && !gp_fault_o;
  endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
endmodule
bind fsp_unit fsp_unit_chk i_fsp_unit_chk (.*);
`default_nettype wire

// [sim/fsp_unit_tb.sv]
// Bench for the fast call unit: drives the decoder side directly.
// Assumes inputs change on falling edges, results one cycle later.
`timescale 1ns/10ps
`default_nettype none
module fsp_unit_tb;
  import fsp_pkg::*;
  logic        sys_clk_i, done_o, gp_fault_o, seg_load_o, e;
  logic        rst_n_i = 1'b0, op_valid_i = 1'b0, long_mode_i = 1'b1;
  logic        code_64_i = 1'b1, ret_to_64_i = 1'b0, int_flag_user_ok_i = 1'b0;
  fsp_op_t     op_i = FSP_OP_NONE;
  fsp_reg_t    wr_reg_i = FSP_REG_OTHER;
  logic [1:0]  cur_priv_i = 2'h0, new_priv_o;
  logic [15:0] code_sel_o, stack_sel_o;
  logic [63:0] wr_data_i = 64'h0, flags_i = 64'h0346, target_ip_o, flags_o;
  logic [63:0] cfg_o, long_tgt_o, compat_tgt_o, mask_o;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  fsp_unit i_fsp_unit (.*);
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [63:0] ex, got);
    cmp_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, ex, got);
    end
  endtask
  // Valid stays high between back-to-back ops
  task automatic op(input fsp_op_t o, input logic [1:0] p);
    op_i = o;
    cur_priv_i = p;
    op_valid_i = 1'b1;
    @(negedge sys_clk_i);
  endtask
  task automatic wr(input fsp_reg_t r, input logic [63:0] d);
    wr_reg_i = r;
    wr_data_i = d;
    op(FSP_OP_MODEL_WRITE, 2'h0);
  endtask
  initial begin
    repeat (20) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    chk("cfg", 64'h0, cfg_o);
    wr(FSP_REG_CFG, 64'h0023_0010_1234_5678);
    wr(FSP_REG_LONG, 64'hffff_8000_0000_1000);
    wr(FSP_REG_COMPAT, 64'h0000_7fff_0000_2000);
    wr(FSP_REG_MASK, 64'h0300);
    wr(FSP_REG_LONG, 64'h0000_8000_0000_0000);
    chk("gp", 64'h1, gp_fault_o);
    chk("long", 64'hffff_8000_0000_1000, long_tgt_o);
    chk("compat", 64'h0000_7fff_0000_2000, compat_tgt_o);
    op(FSP_OP_FAST_CALL, 2'h3);
    chk("seg", 64'h1, seg_load_o);
    chk("cs", 64'h0010, code_sel_o);
    chk("ss", 64'h0018, stack_sel_o);
    chk("pl", 64'h0, new_priv_o);
    chk("ip", 64'hffff_8000_0000_1000, target_ip_o);
    chk("fl", 64'h0046, flags_o);
    code_64_i = 1'b0;
    op(FSP_OP_FAST_CALL, 2'h3);
    chk("ip", 64'h7fff_0000_2000, target_ip_o);
    long_mode_i = 1'b0;
    op(FSP_OP_FAST_CALL, 2'h3);
    chk("ip", 64'h1234_5678, target_ip_o);
    chk("fl", 64'h0346, flags_o);
    op(FSP_OP_FAST_RETURN, 2'h0);
    chk("cs", 64'h0023, code_sel_o);
    chk("ss", 64'h002b, stack_sel_o);
    chk("pl", 64'h3, new_priv_o);
    ret_to_64_i = 1'b1;
    op(FSP_OP_FAST_RETURN, 2'h0);
    chk("cs", 64'h0033, code_sel_o);
    chk("ss", 64'h002b, stack_sel_o);
    wr_reg_i = FSP_REG_MASK;
    for (int k = 1; k <= 20; k++) begin
      op(fsp_op_t'(k[4:0]), 2'h3);
      e = op_i inside {FSP_OP_MODEL_WRITE, FSP_OP_SET_GLOBAL, FSP_OP_BASE_SWAP,
        FSP_OP_LEGACY_RETURN, FSP_OP_FAST_RETURN, FSP_OP_GUEST_LOAD,
        FSP_OP_GUEST_SAVE, FSP_OP_GUEST_RUN, FSP_OP_HYPER_CALL,
        FSP_OP_CACHE_WBINV, FSP_OP_SET_INT_FLAG};
      chk("gp", {63'h0, e}, gp_fault_o);
      chk("done", {63'h0, !e}, done_o);
    end
    chk("mask", 64'h0300, mask_o);
    int_flag_user_ok_i = 1'b1;
    op(FSP_OP_SET_INT_FLAG, 2'h3);
    chk("done", 64'h1, done_o);
    chk("gp", 64'h0, gp_fault_o);
    op_valid_i = 1'b0;
    final_report();
  end
endmodule
`default_nettype wire
